// *** common/msp_pkg.sv ***
// constants for the motor status and parameter register bank
// assumes a 20 MHz core clock and byte-wide register access from the serial engine
package msp_pkg;
    localparam int CLK_PERIOD_NS = 50;
    // status register offsets
    localparam logic [7:0] OFS_PERIOD_HI = 8'h13;
    localparam logic [7:0] OFS_PERIOD_LO = 8'h14;
    localparam logic [7:0] OFS_VCONST_HI = 8'h15;
    localparam logic [7:0] OFS_VCONST_LO = 8'h16;
    localparam logic [7:0] OFS_IPD_POS = 8'h19;
    localparam logic [7:0] OFS_SUPPLY = 8'h1A;
    localparam logic [7:0] OFS_SPEED_ACT = 8'h1B;
    localparam logic [7:0] OFS_SPEED_BUF = 8'h1C;
    localparam logic [7:0] OFS_FAULT = 8'h1E;
    // motor parameter offsets
    localparam logic [7:0] OFS_PARAM_A = 8'h20;
    localparam logic [7:0] OFS_PARAM_B = 8'h21;
    localparam logic [7:0] OFS_PARAM_C = 8'h22;
    // parameter reset values
    localparam logic [7:0] PARAM_A_RST = 8'h4A;
    localparam logic [7:0] PARAM_B_RST = 8'h4E;
    localparam logic [7:0] PARAM_C_RST = 8'h2A;
    // field positions in the parameter registers
    localparam int SEL_BIT = 7;
    localparam int CODE_MSB = 6;
    // speed source select
    localparam logic [1:0] SRC_ANALOG = 2'h0;
    localparam logic [1:0] SRC_PWM = 2'h1;
    // fault bit positions
    localparam int FLT_CLOSED = 5;
    localparam int FLT_OPEN = 4;
    localparam int FLT_NO_MOTOR = 3;
    localparam int FLT_VCONST = 2;
    localparam int FLT_SPEED = 1;
    localparam int FLT_LOCK = 0;
    // timing: one period count is 10 us, one advance step is 2.5 us
    localparam int PERIOD_LSB_NS = 10000;
    localparam logic [7:0] PERIOD_TICK_CYC = 8'(PERIOD_LSB_NS / CLK_PERIOD_NS);
    localparam int ADV_LSB_NS = 2500;
    localparam logic [5:0] ADV_CYC_PER_LSB = 6'(ADV_LSB_NS / CLK_PERIOD_NS);
endpackage : msp_pkg

// *** logic/msp_pair_latch.sv ***
// holds the low byte of a 16-bit word when its high byte is read
// assumes hi_rd_i is a one-cycle read strobe on the core clock
`timescale 1ns/1ps
`default_nettype none
module msp_pair_latch
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [15:0] word_i,
    input wire logic hi_rd_i,
    output logic [7:0] low_o
);
    typedef struct packed {
        logic [7:0] low;
    } msp_pair_st_t;

    msp_pair_st_t st_ff;
    msp_pair_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (hi_rd_i)
        begin
            nxt_st.low = word_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign low_o = st_ff.low;
endmodule : msp_pair_latch
`default_nettype wire

// *** logic/msp_regs.sv ***
// motor status and motor parameter register bank
// assumes byte register access from the serial engine and status inputs on the same clock
`timescale 1ns/1ps
`default_nettype none
module msp_regs
(
    input wire logic clock_i,
    input wire logic nrst_i,
    // register access from the serial engine
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic cfg_wr_en_i,
    output logic [7:0] rdata_o,
    // motor core status
    input wire logic elec_cycle_i,
    input wire logic [14:0] vconst_dig_i,
    input wire logic [7:0] inductive_position_sense_i,
    input wire logic [7:0] ipd_advance_i,
    input wire logic [7:0] supply_level_code_i,
    input wire logic [1:0] speed_src_i,
    input wire logic [7:0] analog_speed_i,
    input wire logic [7:0] pwm_speed_i,
    input wire logic [7:0] serial_speed_i,
    input wire logic [8:0] speed_buffer_i,
    input wire logic stuck_closed_loop_flag_i,
    input wire logic stuck_open_loop_flag_i,
    input wire logic no_motor_flag_i,
    input wire logic velocity_const_abnormal_flag_i,
    input wire logic speed_abnormal_flag_i,
    input wire logic lock_current_limit_flag_i,
    // decoded motor parameters
    output logic output_freq_select_o,
    output logic [10:0] phase_resistance_o,
    output logic closed_loop_adjust_select_o,
    output logic [10:0] back_emf_constant_o,
    output logic advance_time_select_o,
    output logic [16:0] advance_delay_time_o
);
    typedef struct packed {
        logic [7:0] tick;
        logic [15:0] per_cnt;
        logic [15:0] per;
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
        logic [5:0] flt;
        logic [7:0] rdata;
        logic freq;
        logic adj;
        logic adv;
        logic [10:0] rm;
        logic [10:0] kt;
        logic [16:0] delay;
    } msp_regs_st_t;

    msp_regs_st_t st_ff;
    msp_regs_st_t nxt_st;

    logic [15:0] vconst_word;
    logic [7:0] per_low_held;
    logic [7:0] vconst_low_held;
    logic [7:0] active_speed_command;
    logic [5:0] fault_events;
    logic [10:0] rm_dec;
    logic [10:0] kt_dec;
    logic [10:0] adv_dec;
    logic per_hi_rd;
    logic vc_hi_rd;
    logic param_wr;

    assign vconst_word = {vconst_dig_i, 1'b0};
    assign per_hi_rd = rd_i && (addr_i == msp_pkg::OFS_PERIOD_HI);
    assign vc_hi_rd = rd_i && (addr_i == msp_pkg::OFS_VCONST_HI);
    assign param_wr = wr_i && cfg_wr_en_i;

    // active source mux; serial covers both remaining codes
    always_comb
    begin
        case (speed_src_i)
            msp_pkg::SRC_ANALOG: active_speed_command = analog_speed_i;
            msp_pkg::SRC_PWM: active_speed_command = pwm_speed_i;
            default: active_speed_command = serial_speed_i;
        endcase
    end

    always_comb
    begin
        fault_events = '0;
        fault_events[msp_pkg::FLT_CLOSED] = stuck_closed_loop_flag_i;
        fault_events[msp_pkg::FLT_OPEN] = stuck_open_loop_flag_i;
        fault_events[msp_pkg::FLT_NO_MOTOR] = no_motor_flag_i;
        fault_events[msp_pkg::FLT_VCONST] = velocity_const_abnormal_flag_i;
        fault_events[msp_pkg::FLT_SPEED] = speed_abnormal_flag_i;
        fault_events[msp_pkg::FLT_LOCK] = lock_current_limit_flag_i;
    end

    // low bytes are frozen at the high-byte read so a pair never tears
    msp_pair_latch u_per_pair
    (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .word_i(st_ff.per),
        .hi_rd_i(per_hi_rd),
        .low_o(per_low_held)
    );

    msp_pair_latch u_vc_pair
    (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .word_i(vconst_word),
        .hi_rd_i(vc_hi_rd),
        .low_o(vconst_low_held)
    );

    msp_shift_dec u_rm_dec
    (
        .code_i(st_ff.pa[msp_pkg::CODE_MSB:0]),
        .value_o(rm_dec)
    );

    msp_shift_dec u_kt_dec
    (
        .code_i(st_ff.pb[msp_pkg::CODE_MSB:0]),
        .value_o(kt_dec)
    );

    msp_shift_dec u_adv_dec
    (
        .code_i(st_ff.pc[msp_pkg::CODE_MSB:0]),
        .value_o(adv_dec)
    );

    always_comb
    begin
        nxt_st = st_ff;
        // 10 us time base; period counter saturates rather than wraps on a stalled rotor
        if (st_ff.tick == msp_pkg::PERIOD_TICK_CYC - 8'h01)
        begin
            nxt_st.tick = '0;
            if (st_ff.per_cnt != 16'hFFFF)
            begin
                nxt_st.per_cnt = st_ff.per_cnt + 16'h0001;
            end
        end
        else
        begin
            nxt_st.tick = st_ff.tick + 8'h01;
        end
        if (elec_cycle_i)
        begin
            nxt_st.per = st_ff.per_cnt;
            nxt_st.per_cnt = '0;
        end
        // parameter writes
        if (param_wr && addr_i == msp_pkg::OFS_PARAM_A)
        begin
            nxt_st.pa = wdata_i;
        end
        if (param_wr && addr_i == msp_pkg::OFS_PARAM_B)
        begin
            nxt_st.pb = wdata_i;
        end
        if (param_wr && addr_i == msp_pkg::OFS_PARAM_C)
        begin
            nxt_st.pc = wdata_i;
        end
        // faults clear on read, but a new event in that cycle wins
        if (rd_i && addr_i == msp_pkg::OFS_FAULT)
        begin
            nxt_st.flt = fault_events;
        end
        else
        begin
            nxt_st.flt = st_ff.flt | fault_events;
        end
        // decoded parameters, one cycle behind the register
        nxt_st.freq = st_ff.pa[msp_pkg::SEL_BIT];
        nxt_st.rm = rm_dec;
        nxt_st.adj = st_ff.pb[msp_pkg::SEL_BIT];
        nxt_st.kt = kt_dec;
        nxt_st.adv = st_ff.pc[msp_pkg::SEL_BIT];
        // widen both factors first: the largest product needs all 17 bits
        nxt_st.delay = 17'(adv_dec) * 17'(msp_pkg::ADV_CYC_PER_LSB);
        // read data
        if (rd_i)
        begin
            case (addr_i)
                msp_pkg::OFS_PERIOD_HI: nxt_st.rdata = st_ff.per[15:8];
                msp_pkg::OFS_PERIOD_LO: nxt_st.rdata = per_low_held;
                msp_pkg::OFS_VCONST_HI: nxt_st.rdata = vconst_word[15:8];
                msp_pkg::OFS_VCONST_LO: nxt_st.rdata = vconst_low_held;
                msp_pkg::OFS_IPD_POS: nxt_st.rdata = 8'(inductive_position_sense_i + ipd_advance_i);
                msp_pkg::OFS_SUPPLY: nxt_st.rdata = supply_level_code_i;
                msp_pkg::OFS_SPEED_ACT: nxt_st.rdata = active_speed_command;
                msp_pkg::OFS_SPEED_BUF: nxt_st.rdata = speed_buffer_i[8:1];
                msp_pkg::OFS_FAULT: nxt_st.rdata = {2'b00, st_ff.flt};
                msp_pkg::OFS_PARAM_A: nxt_st.rdata = st_ff.pa;
                msp_pkg::OFS_PARAM_B: nxt_st.rdata = st_ff.pb;
                msp_pkg::OFS_PARAM_C: nxt_st.rdata = st_ff.pc;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_ff <= '0;
            st_ff.pa <= msp_pkg::PARAM_A_RST;
            st_ff.pb <= msp_pkg::PARAM_B_RST;
            st_ff.pc <= msp_pkg::PARAM_C_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign output_freq_select_o = st_ff.freq;
    assign phase_resistance_o = st_ff.rm;
    assign closed_loop_adjust_select_o = st_ff.adj;
    assign back_emf_constant_o = st_ff.kt;
    assign advance_time_select_o = st_ff.adv;
    assign advance_delay_time_o = st_ff.delay;

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    a_period_capture: assert property (elec_cycle_i |=> st_ff.per == $past(st_ff.per_cnt))
        else $error("period not captured on electrical cycle");
    a_period_tick: assert property ((st_ff.per_cnt != $past(st_ff.per_cnt)) && !$past(elec_cycle_i)
        |-> $past(st_ff.tick) == msp_pkg::PERIOD_TICK_CYC - 8'h01)
        else $error("period count moved off the 10 us tick");
    a_pair_low: assert property (per_hi_rd ##1 (rd_i && addr_i == msp_pkg::OFS_PERIOD_LO)
        |=> rdata_o == $past(st_ff.per[7:0], 2))
        else $error("period low byte not coherent with high byte");
    a_pair_hold: assert property (per_hi_rd |=> per_low_held == $past(st_ff.per[7:0]))
        else $error("period low byte not held at high byte read");
    a_vc_pair_hold: assert property (vc_hi_rd |=> vconst_low_held == $past({vconst_dig_i[6:0], 1'b0}))
        else $error("velocity constant low byte not held at high byte read");
    a_vconst_hi: assert property (vc_hi_rd |=> rdata_o == $past(vconst_dig_i[14:7]))
        else $error("velocity constant high byte wrong");
    a_ipd_sum: assert property ((rd_i && addr_i == msp_pkg::OFS_IPD_POS)
        |=> rdata_o == 8'($past(inductive_position_sense_i) + $past(ipd_advance_i)))
        else $error("position byte is not estimate plus advance");
    a_supply_read: assert property ((rd_i && addr_i == msp_pkg::OFS_SUPPLY)
        |=> rdata_o == $past(supply_level_code_i))
        else $error("supply code read wrong");
    a_speed_analog: assert property ((rd_i && addr_i == msp_pkg::OFS_SPEED_ACT && speed_src_i == 2'h0)
        |=> rdata_o == $past(analog_speed_i))
        else $error("analog speed command not selected");
    a_speed_serial: assert property ((rd_i && addr_i == msp_pkg::OFS_SPEED_ACT && speed_src_i[1])
        |=> rdata_o == $past(serial_speed_i))
        else $error("serial speed command not selected");
    a_speed_buf: assert property ((rd_i && addr_i == msp_pkg::OFS_SPEED_BUF)
        |=> rdata_o == $past(speed_buffer_i[8:1]))
        else $error("buffered speed bits wrong");
    a_fault_sticky: assert property (no_motor_flag_i ##1 !(rd_i && addr_i == msp_pkg::OFS_FAULT)
        |=> st_ff.flt[msp_pkg::FLT_NO_MOTOR])
        else $error("no-motor flag lost");
    a_fault_top: assert property ((rd_i && addr_i == msp_pkg::OFS_FAULT) |=> rdata_o[7:6] == 2'b00)
        else $error("unused fault bits not zero");
    a_fault_read: assert property ((rd_i && addr_i == msp_pkg::OFS_FAULT)
        |=> rdata_o[5:0] == $past(st_ff.flt))
        else $error("fault read does not show held flags");
    a_fault_clear: assert property ((rd_i && addr_i == msp_pkg::OFS_FAULT && fault_events == 6'h00)
        |=> st_ff.flt == 6'h00)
        else $error("fault flags not cleared by read");
    a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    a_cfg_locked: assert property ((wr_i && !cfg_wr_en_i) |=> $stable(st_ff.pa) && $stable(st_ff.pb)
        && $stable(st_ff.pc))
        else $error("parameter changed without write enable");
    a_cfg_write: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_A)
        |=> st_ff.pa == $past(wdata_i))
        else $error("enabled parameter write lost");
    a_rm_decode: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_A) ##1 !wr_i
        |=> phase_resistance_o == ({7'h00, $past(wdata_i[3:0], 2)} << $past(wdata_i[6:4], 2)))
        else $error("phase resistance decode wrong");
    a_freq_sel: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_A) ##1 !wr_i
        |=> output_freq_select_o == $past(wdata_i[7], 2))
        else $error("output frequency select wrong");
    a_kt_decode: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_B) ##1 !wr_i
        |=> back_emf_constant_o == ({7'h00, $past(wdata_i[3:0], 2)} << $past(wdata_i[6:4], 2)))
        else $error("back-EMF constant decode wrong");
    a_adj_sel: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_B) ##1 !wr_i
        |=> closed_loop_adjust_select_o == $past(wdata_i[7], 2))
        else $error("closed-loop adjust select wrong");
    a_adv_sel: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_C) ##1 !wr_i
        |=> advance_time_select_o == $past(wdata_i[7], 2))
        else $error("advance time select wrong");
    // the cycle factor is written out here so a wrong package constant shows up
    a_adv_delay: assert property ((param_wr && addr_i == msp_pkg::OFS_PARAM_C) ##1 !wr_i
        |=> advance_delay_time_o == 17'(({7'h00, $past(wdata_i[3:0], 2)} << $past(wdata_i[6:4], 2)) * 50))
        else $error("advance delay cycles wrong");

    c_period: cover property (elec_cycle_i && st_ff.per_cnt != 16'h0000);
    c_pair_read: cover property (per_hi_rd ##[1:2] (rd_i && addr_i == msp_pkg::OFS_PERIOD_LO));
    c_cfg_refused: cover property (wr_i && !cfg_wr_en_i && addr_i == msp_pkg::OFS_PARAM_A);
    c_fault_read: cover property ((rd_i && addr_i == msp_pkg::OFS_FAULT) && st_ff.flt != 6'h00);
    c_param_write: cover property (param_wr && addr_i == msp_pkg::OFS_PARAM_C);
endmodule : msp_regs
`default_nettype wire

// *** logic/msp_shift_dec.sv ***
// shift/significand decoder: 4-bit significand shifted left by a 3-bit count
// assumes the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module msp_shift_dec
(
    input wire logic [6:0] code_i,
    output logic [10:0] value_o
);
    always_comb
    begin
        value_o = {7'h00, code_i[3:0]} << code_i[6:4];
    end
endmodule : msp_shift_dec
`default_nettype wire

// *** tb/msp_host_model.sv ***
// host side of the register port: byte reads and writes with one-cycle strobes
// assumes callers wait for reset release before the first access
`timescale 1ns/1ps
`default_nettype none
module msp_host_model
(
    input wire logic clock_i,
    output var logic [7:0] addr_o,
    output var logic [7:0] wdata_o,
    output var logic wr_o,
    output var logic rd_o,
    output var logic cfg_wr_en_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        cfg_wr_en_o = 1'b0;
    end

    // callers read a high byte before its low byte
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock_i);
        #2;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clock_i);
        #2;
        rd_o = 1'b0;
        // released address must not look like the last one
        addr_o = ~a;
    endtask : rd_reg

    // enable level travels with the write so a refused write is easy to make
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic en);
        @(posedge clock_i);
        #2;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        cfg_wr_en_o = en;
        @(posedge clock_i);
        #2;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr_reg
endmodule : msp_host_model
`default_nettype wire

// *** tb/tb_msp_regs.sv ***
// self-checking bench for the motor status and parameter register bank
// assumes the host model drives the register port; status inputs are driven here
`timescale 1ns/1ps
`default_nettype none
module tb_msp_regs;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, cfg_en, elec = 1'b0;
    logic [14:0] vconst = 15'h0000;
    logic [7:0] ipd_s = 8'h00, ipd_a = 8'h00, sup = 8'h00, ana = 8'h00, pwm = 8'h00, ser = 8'h00;
    logic [1:0] src = 2'h0;
    logic [8:0] sbuf = 9'h000;
    logic [5:0] flt = 6'h00;
    logic freq, adj, adv;
    logic [10:0] rm, kt;
    logic [16:0] dly;
    logic [7:0] exp_q[$], tol_q[$];
    logic [7:0] pa, pb, pc;
    logic [15:0] vw;
    logic chk_rd = 1'b0;
    int bad_count = 0, samples_checked = 0, cyc = 0;

    always #25 clock_i = ~clock_i;

    msp_host_model host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .cfg_wr_en_o(cfg_en));

    msp_regs uut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .cfg_wr_en_i(cfg_en), .rdata_o(rdata), .elec_cycle_i(elec), .vconst_dig_i(vconst),
        .inductive_position_sense_i(ipd_s), .ipd_advance_i(ipd_a), .supply_level_code_i(sup),
        .speed_src_i(src), .analog_speed_i(ana), .pwm_speed_i(pwm), .serial_speed_i(ser),
        .speed_buffer_i(sbuf), .stuck_closed_loop_flag_i(flt[5]), .stuck_open_loop_flag_i(flt[4]),
        .no_motor_flag_i(flt[3]), .velocity_const_abnormal_flag_i(flt[2]), .speed_abnormal_flag_i(flt[1]),
        .lock_current_limit_flag_i(flt[0]), .output_freq_select_o(freq), .phase_resistance_o(rm),
        .closed_loop_adjust_select_o(adj), .back_emf_constant_o(kt), .advance_time_select_o(adv),
        .advance_delay_time_o(dly));

    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic cmp_val(input logic [16:0] got, input logic [16:0] e);
        samples_checked++;
        if (got !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask : cmp_val

    // tolerance covers the free-running tick counter's one-count jitter
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e, input logic [7:0] t);
        logic ok;
        ok = 1'b0;
        for (int d = 0; d <= 2 * t; d++)
            if (got === 8'(e - t + d))
                ok = 1'b1;
        samples_checked++;
        if (!ok)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask : cmp_rd

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] t);
        exp_q.push_back(e);
        tol_q.push_back(t);
        host.rd_reg(a);
    endtask : rd_exp

    task automatic chk_dec(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        cmp_val(17'(freq), 17'(a[7]));
        cmp_val(17'(rm), 17'(a[3:0]) << a[6:4]);
        cmp_val(17'(adj), 17'(b[7]));
        cmp_val(17'(kt), 17'(b[3:0]) << b[6:4]);
        cmp_val(17'(adv), 17'(c[7]));
        cmp_val(dly, (17'(c[3:0]) << c[6:4]) * 17'd50);
    endtask : chk_dec

    // read data stands from the take edge, so it is compared one edge later
    always @(posedge clock_i)
    begin
        if (chk_rd && exp_q.size() > 0)
            cmp_rd(rdata, exp_q.pop_front(), tol_q.pop_front());
        chk_rd = rd;
    end

    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(63938));
        repeat (6) @(posedge clock_i);
        #2;
        nrst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #2;
        chk_dec(msp_pkg::PARAM_A_RST, msp_pkg::PARAM_B_RST, msp_pkg::PARAM_C_RST);
        host.wr_reg(msp_pkg::OFS_PARAM_A, 8'h00, 1'b0);
        rd_exp(msp_pkg::OFS_PARAM_A, msp_pkg::PARAM_A_RST, 8'h00);
        repeat (3)
        begin
            pa = 8'($urandom);
            pb = 8'($urandom);
            pc = 8'($urandom);
            host.wr_reg(msp_pkg::OFS_PARAM_A, pa, 1'b1);
            host.wr_reg(msp_pkg::OFS_PARAM_B, pb, 1'b1);
            host.wr_reg(msp_pkg::OFS_PARAM_C, pc, 1'b1);
            rd_exp(msp_pkg::OFS_PARAM_A, pa, 8'h00);
            rd_exp(msp_pkg::OFS_PARAM_B, pb, 8'h00);
            rd_exp(msp_pkg::OFS_PARAM_C, pc, 8'h00);
            chk_dec(pa, pb, pc);
        end
        {ipd_s, ipd_a, sup, ana, pwm, ser} = 48'({$urandom, $urandom});
        sbuf = 9'($urandom);
        vconst = 15'($urandom);
        rd_exp(msp_pkg::OFS_IPD_POS, 8'(ipd_s + ipd_a), 8'h00);
        rd_exp(msp_pkg::OFS_SUPPLY, sup, 8'h00);
        rd_exp(msp_pkg::OFS_SPEED_BUF, sbuf[8:1], 8'h00);
        rd_exp(8'h17, 8'h00, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            src = 2'(s);
            rd_exp(msp_pkg::OFS_SPEED_ACT, (s == 0) ? ana : (s == 1) ? pwm : ser, 8'h00);
        end
        vw = {vconst, 1'b0};
        rd_exp(msp_pkg::OFS_VCONST_HI, vw[15:8], 8'h00);
        vconst = ~vconst;
        rd_exp(msp_pkg::OFS_VCONST_LO, vw[7:0], 8'h00);
        repeat (2)
        begin
            elec = 1'b1;
            @(posedge clock_i);
            #2;
            elec = 1'b0;
            repeat (599) @(posedge clock_i);
            #2;
        end
        rd_exp(msp_pkg::OFS_PERIOD_HI, 8'h00, 8'h00);
        rd_exp(msp_pkg::OFS_PERIOD_LO, 8'h03, 8'h01);
        for (int b = 0; b < 6; b++)
        begin
            flt = 6'(1 << b);
            @(posedge clock_i);
            #2;
            flt = 6'h00;
            rd_exp(msp_pkg::OFS_FAULT, 8'(1 << b), 8'h00);
            rd_exp(msp_pkg::OFS_FAULT, 8'h00, 8'h00);
        end
        repeat (3) @(posedge clock_i);
        summarize();
    end
endmodule : tb_msp_regs
`default_nettype wire
